// file: wwd_pkg.sv
// constants for the window watchdog
package wwd_pkg;
  // clock and timing
  localparam int unsigned CLK_FREQ_HZ       = 20_000_000;
  localparam int unsigned CYC_PER_MS        = CLK_FREQ_HZ / 1000;
  localparam int unsigned BASE_PERIOD_MS    = 10;
  localparam int unsigned BASE_PERIOD_CYC   = BASE_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned INIT_TIMEOUT_MS   = 100;
  localparam int unsigned INIT_TIMEOUT_CYC  = INIT_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned CNT_W             = 32;

  // register map
  localparam logic [7:0] CFG_OFFSET         = 8'h10;
  localparam logic [7:0] SERVICE_OFFSET     = 8'h11;

  // config register fields
  localparam int unsigned DISABLED_BIT      = 7;
  localparam int unsigned WINDOW_OPEN_BIT   = 6;
  localparam int unsigned SEL_MSB           = 2;
  localparam logic [2:0]  SEL_RESET         = 3'h0;

  // service values
  localparam logic [7:0] SERVICE_FIRST      = 8'hAA;
  localparam logic [7:0] SERVICE_SECOND     = 8'h55;

  // watchdog states
  typedef enum logic [1:0] {
    WWD_HALT    = 2'b00,
    WWD_INIT    = 2'b01,
    WWD_WINDOW  = 2'b10,
    WWD_RSTWAIT = 2'b11
  } wwd_state_type;
endpackage

// file: wwd_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module wwd_sync (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: wwd_top.sv
// window watchdog with config and service registers
`timescale 1ns/10ps
`default_nettype none
// Operation
// - The watchdog supervises only in normal mode and idles in low power.
// - The counter runs on the base clock, apart from register access timing.
// - A three-bit select sets the period from 10 ms doubling up to 1280 ms.
// - After reset a fixed plain timeout runs, window flag set, select free.
// - Initial timeout without service or a first value not 0xAA resets.
// - In windowed mode the first half of the period refuses a clear.
// - The expected value in the open window clears and flips expectation.
// - Period expiry or a wrong value in windowed mode forces a reset.
// - Bit 6 of the config register shows the window is open.
// - Bit 7 shows external disable and reads set during stop mode.
// - Test disable holds the watchdog off, resets service, then reinits.
// - Service writes while disabled are ignored entirely.
// - Low power stops the counter and resets the service register.
module wwd_top
  import wwd_pkg::*;
#(
  parameter int unsigned BASE_CYCLES  = BASE_PERIOD_CYC,
  parameter int unsigned INIT_CYCLES  = INIT_TIMEOUT_CYC,
  parameter bit          CLOSED_RESET = 1'b1
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       normal_mode,
  input  wire logic       stop_mode,
  input  wire logic       test_disable,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_q,
  output logic            wdt_reset_req_q,
  output logic            window_open_flag_q,
  output logic            disabled_flag_q
);
  wwd_state_type      state_q, state_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [2:0]         timeout_select_q;
  logic               expect_second_q, expect_second_d;
  logic               normal_s, stop_s, test_s;
  logic               req_d;

  // mode pins cross into the watchdog clock
  wwd_sync u_sync_normal (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (normal_mode),
    .sync_out (normal_s)
  );
  wwd_sync u_sync_stop (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (stop_mode),
    .sync_out (stop_s)
  );
  wwd_sync u_sync_test (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (test_disable),
    .sync_out (test_s)
  );

  // decode and derived timing
  wire              active_w   = normal_s & ~test_s;
  wire              cfg_sel_w  = (reg_addr == CFG_OFFSET);
  wire              svc_sel_w  = (reg_addr == SERVICE_OFFSET);
  wire              cfg_wr_w   = reg_wr & cfg_sel_w;
  wire              svc_wr_w   = reg_wr & svc_sel_w & active_w;
  wire [CNT_W-1:0]  base_w     = CNT_W'(BASE_CYCLES);
  wire [CNT_W-1:0]  period_w   = base_w << timeout_select_q;
  wire [CNT_W-1:0]  half_w     = period_w >> 1;
  wire [CNT_W-1:0]  init_end_w = CNT_W'(INIT_CYCLES - 1);
  wire              in_open_w  = (cnt_q >= half_w);
  wire              open_w     = (state_q == WWD_INIT) |
                                 ((state_q == WWD_WINDOW) & in_open_w);
  wire [7:0]        expect_w   = expect_second_q ? SERVICE_SECOND
                                                 : SERVICE_FIRST;
  wire              disabled_w = test_s | stop_s;
  wire [7:0]        cfg_rd_w   = {disabled_w, open_w, 3'h0,
                                  timeout_select_q};

  // watchdog sequencing
  always_comb begin
    state_d         = state_q;
    cnt_d           = cnt_q + 1'b1;
    expect_second_d = expect_second_q;
    req_d           = 1'b0;
    case (state_q)
      WWD_HALT: begin
        cnt_d = '0;
        if (active_w) begin
          state_d = WWD_INIT;
        end
      end
      WWD_INIT: begin
        if (svc_wr_w) begin
          if (reg_wdata == SERVICE_FIRST) begin
            state_d         = WWD_WINDOW;
            cnt_d           = '0;
            expect_second_d = 1'b1;
          end else begin
            req_d   = 1'b1;
            state_d = WWD_RSTWAIT;
          end
        end else if (cnt_q >= init_end_w) begin
          req_d   = 1'b1;
          state_d = WWD_RSTWAIT;
        end
      end
      WWD_WINDOW: begin
        if (svc_wr_w) begin
          if (!in_open_w) begin
            if (CLOSED_RESET) begin
              req_d   = 1'b1;
              state_d = WWD_RSTWAIT;
            end
          end else if (reg_wdata == expect_w) begin
            cnt_d           = '0;
            expect_second_d = ~expect_second_q;
          end else begin
            req_d   = 1'b1;
            state_d = WWD_RSTWAIT;
          end
        end else if (cnt_q >= period_w - 1'b1) begin
          req_d   = 1'b1;
          state_d = WWD_RSTWAIT;
        end
      end
      WWD_RSTWAIT: begin
        cnt_d = cnt_q;
      end
      default: begin
        state_d = WWD_HALT;
      end
    endcase
    if (!active_w && state_q != WWD_RSTWAIT) begin
      state_d         = WWD_HALT;
      cnt_d           = '0;
      expect_second_d = 1'b0;
      req_d           = 1'b0;
    end
  end

  // state and counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q         <= WWD_INIT;
      cnt_q           <= '0;
      expect_second_q <= 1'b0;
      wdt_reset_req_q <= 1'b0;
    end else begin
      state_q         <= state_d;
      cnt_q           <= cnt_d;
      expect_second_q <= expect_second_d;
      wdt_reset_req_q <= req_d;
    end
  end

  // config register and read port
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_select_q   <= SEL_RESET;
      reg_rdata_q        <= 8'h00;
      window_open_flag_q <= 1'b0;
      disabled_flag_q    <= 1'b0;
    end else begin
      if (cfg_wr_w) begin
        timeout_select_q <= reg_wdata[SEL_MSB:0];
      end
      if (reg_rd) begin
        reg_rdata_q <= cfg_sel_w ? cfg_rd_w : 8'h00;
      end
      window_open_flag_q <= open_w;
      disabled_flag_q    <= disabled_w;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence good_first_s;
    state_q == WWD_INIT && active_w && svc_wr_w &&
      reg_wdata == SERVICE_FIRST;
  endsequence

  req_single_a: assert property (
    wdt_reset_req_q |=> !wdt_reset_req_q [*3])
    else $error("reset request longer than one cycle");
  first_bad_a: assert property (
    (state_q == WWD_INIT && active_w && svc_wr_w &&
     reg_wdata != SERVICE_FIRST) |=> wdt_reset_req_q)
    else $error("wrong first service value did not reset");
  init_expire_a: assert property (
    (state_q == WWD_INIT && active_w && !svc_wr_w &&
     cnt_q == init_end_w) |=> wdt_reset_req_q)
    else $error("initial timeout without reset");
  first_good_a: assert property (
    good_first_s |=> state_q == WWD_WINDOW && cnt_q == 0 &&
                     expect_w == SERVICE_SECOND)
    else $error("first service did not enter windowed mode");
  closed_keep_a: assert property (
    (state_q == WWD_WINDOW && active_w && svc_wr_w && !in_open_w)
      |=> cnt_q == $past(cnt_q) + 1 || wdt_reset_req_q)
    else $error("closed window write cleared the counter");
  closed_flag_a: assert property (
    (state_q == WWD_WINDOW && !in_open_w) |=> !window_open_flag_q)
    else $error("window flag set in closed half");
  expire_a: assert property (
    (state_q == WWD_WINDOW && active_w && !svc_wr_w &&
     cnt_q == period_w - 1) |=> wdt_reset_req_q)
    else $error("period expiry without reset");
  ignore_off_a: assert property (
    (!active_w && reg_wr && svc_sel_w) |=> !wdt_reset_req_q)
    else $error("write while disabled caused reset");
  halt_clear_a: assert property (
    (!active_w && state_q != WWD_RSTWAIT)
      |=> state_q == WWD_HALT && cnt_q == 0 && !expect_second_q)
    else $error("inactive watchdog not halted");
  stop_read_a: assert property (
    (reg_rd && cfg_sel_w && stop_s) |=> reg_rdata_q[DISABLED_BIT])
    else $error("stop read missing disabled flag");
endmodule
`default_nettype wire

// file: wwd_host.sv
// host model for the watchdog register port
`timescale 1ns/10ps
`default_nettype none
module wwd_host
  import wwd_pkg::*;
(
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // bus idle at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one strobe cycle; released lines then show inverted values
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge core_clk);
    #2;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // service write: one write of the given value to the service register
  task automatic serve(input logic [7:0] d);
    xfer(1'b1, SERVICE_OFFSET, d);
  endtask
endmodule
`default_nettype wire

// file: wwd_top_tb.sv
// self-checking bench for the window watchdog
`timescale 1ns/10ps
`default_nettype none
module wwd_top_tb
  import wwd_pkg::*;
;
  localparam int unsigned BC = 16;
  localparam int unsigned IC = 40;
  logic       core_clk = 1'b0;
  logic       arst_n, normal_mode, stop_mode, test_disable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, v;
  logic       reg_wr, reg_rd, wdt_reset_req_q;
  logic       window_open_flag_q, disabled_flag_q;
  logic       rd_seen = 1'b0;
  logic [8:0] exp_q[$];
  logic [8:0] note;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cycles = 0;
  int         p;
  wwd_host host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  wwd_top #(.BASE_CYCLES(BC), .INIT_CYCLES(IC)) dut (.core_clk,
    .arst_n, .normal_mode, .stop_mode, .test_disable, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .wdt_reset_req_q,
    .window_open_flag_q, .disabled_flag_q);
  // 50 ns clock
  always #25 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [8:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    chk("notes left", 9'(exp_q.size()), 9'h000);
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // read data and reset pulses against the oldest note
  always @(posedge core_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen || wdt_reset_req_q) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
      if (rd_seen)
        chk("read data", {1'b0, reg_rdata_q}, note);
      else
        chk("reset request", 9'h100, note);
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic restart();
    @(posedge core_clk);
    #2;
    arst_n = 1'b0;
    idle(4);
    #2;
    arst_n = 1'b1;
    idle(3);
  endtask
  task automatic rd_cfg(input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    host.xfer(1'b0, CFG_OFFSET, 8'h00);
  endtask
  task automatic bad(input logic [7:0] d);
    exp_q.push_back(9'h100);
    host.serve(d);
    idle(3);
  endtask
  // main sequence
  initial begin
    arst_n = 1'b0;
    normal_mode = 1'b1;
    stop_mode = 1'b0;
    test_disable = 1'b0;
    v = 8'($urandom(30));
    restart();
    rd_cfg(8'h40);
    host.xfer(1'b1, CFG_OFFSET, 8'hFF);
    rd_cfg(8'h47);
    host.xfer(1'b1, 8'h3C, SERVICE_FIRST);
    idle(IC - 14);
    bad(8'h00);
    idle(9);
    $display("test initial done");
    // initial timeout must fire no later than its count
    restart();
    exp_q.push_back(9'h100);
    idle(IC);
    restart();
    v = 8'($urandom);
    if (v == SERVICE_FIRST) v = 8'h00;
    bad(v);
    restart();
    host.serve(SERVICE_FIRST);
    idle(2);
    rd_cfg(8'h00);
    bad(SERVICE_SECOND);
    $display("test first write done");
    for (int s = 0; s < 8; s++) begin
      p = BC << s;
      restart();
      host.xfer(1'b1, CFG_OFFSET, s[7:0]);
      host.serve(SERVICE_FIRST);
      idle(p / 2 + 2);
      rd_cfg({5'b01000, s[2:0]});
      host.serve(SERVICE_SECOND);
      idle(p / 2 + 2);
      host.serve(SERVICE_FIRST);
      idle(p / 2 + 2);
      if (s == 0) begin
        bad(SERVICE_FIRST);
      end else if (s[0]) begin
        idle(p / 2 - 6);
        bad(8'h00);
        idle(9);
      end else begin
        // unserved period: pulse must land no later than its last count
        exp_q.push_back(9'h100);
        idle(p / 2 - 2);
      end
    end
    $display("test window done");
    restart();
    host.serve(SERVICE_FIRST);
    test_disable = 1'b1;
    idle(4);
    #2;
    chk("disabled flag", {8'h00, disabled_flag_q}, 9'h001);
    host.serve(SERVICE_SECOND);
    idle(IC + 8);
    #2;
    test_disable = 1'b0;
    idle(4);
    bad(SERVICE_SECOND);
    restart();
    host.serve(SERVICE_FIRST);
    normal_mode = 1'b0;
    stop_mode = 1'b1;
    idle(4);
    #2;
    chk("disabled flag", {8'h00, disabled_flag_q}, 9'h001);
    rd_cfg(8'h80);
    host.serve(SERVICE_FIRST);
    idle(IC + 8);
    #2;
    normal_mode = 1'b1;
    stop_mode = 1'b0;
    idle(4);
    bad(SERVICE_SECOND);
    $display("test disable done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
